// >>> common/hbd_pkg.sv
// Shared constants for the H-bridge control and SPI diagnostic block.
// Assumes a 125 MHz system clock and an SPI master on a clock of its own.
package hbd_pkg;

  // System clock period and derived timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int ACCESS_TIME_NS = 8350;
  localparam int ACCESS_CYCLES =
    (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LIMIT_OFF_NS = 20000;
  localparam int LIMIT_OFF_CYCLES_DEF = LIMIT_OFF_NS / CLK_PERIOD_NS;
  localparam int MAX_BAUD = 2000000;
  localparam int BUSY_W = $clog2(ACCESS_CYCLES + 1);
  localparam int LIMIT_W = 16;

  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int OP_BITS = 6;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ADDR_LAST = 5'h01;
  localparam logic [CNT_W-1:0] CNT_CHK_FIRST = 5'h02;
  localparam logic [CNT_W-1:0] CNT_OP_LAST = 5'h07;
  localparam logic [CNT_W-1:0] CNT_DATA_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] CNT_FRAME = 5'h10;
  localparam logic [CNT_W-1:0] CNT_OVER = 5'h11;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 14;
  localparam int OP_HI = 13;
  localparam int OP_LO = 8;

  // Instruction byte contents
  localparam logic [1:0] CHIP_ADDR = 2'h0;
  localparam logic [OP_BITS-1:0] OP_IDENT = 6'h00;
  localparam logic [OP_BITS-1:0] OP_VERSION = 6'h03;
  localparam logic [OP_BITS-1:0] OP_DIAG = 6'h09;
  localparam logic [7:0] DATA_UNUSED = 8'hff;
  localparam logic [4:0] CHECK_PATTERN = 5'h15;

  // Diagnostic register
  localparam logic [7:0] DIAG_RESET = 8'hff;
  localparam int DIAG_ACTIVE = 7;

  // Positions in the synchronised pin vector
  localparam int P_SHUTOFF = 0;
  localparam int P_PERMIT = 1;
  localparam int P_IN_A = 2;
  localparam int P_IN_B = 3;
  localparam int P_SHORT_A = 4;
  localparam int P_SHORT_B = 5;
  localparam int P_SHORT_AB = 6;
  localparam int P_OVERCUR = 7;
  localparam int P_OVERTEMP = 8;
  localparam int P_UNDERV = 9;
  localparam int P_CURLIM = 10;
  localparam int P_CURRED = 11;
  localparam int P_NEG_A = 12;
  localparam int P_NEG_B = 13;
  localparam int P_ODIAG = 14;
  localparam int P_SS = 18;
  localparam int P_DMS = 19;
  localparam int PIN_W = 20;

  typedef enum logic [0:0] {EX_IDLE, EX_FRAME} hbd_exec_t;

endpackage : hbd_pkg

// >>> design/hbd_spi_link.sv
// SPI slave shift logic running on the master's serial clock.
// Assumes the clock stops outside frames; results stay put after the frame.
module hbd_spi_link
  import hbd_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] REVISION = 8'h00
)(
  input wire logic i_spi_clk,
  input wire logic i_link_rst,
  input wire logic i_ss_n,
  input wire logic i_sdi,
  input wire logic i_prev_err,
  input wire logic [7:0] i_diag,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  output logic [CNT_W-1:0] o_res_cnt,
  output logic [FRAME_BITS-1:0] o_res_word,
  output logic o_res_tgl
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [FRAME_BITS-1:0] shift;
    logic addr_ok;
    logic [OP_BITS-1:0] op;
  } hbd_frame_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [FRAME_BITS-1:0] word;
    logic tgl;
  } hbd_result_t;

  typedef struct packed {
    logic sdo;
    logic oe_n;
  } hbd_tx_t;

  hbd_frame_t fr_ff, nxt_fr;
  hbd_result_t res_ff, nxt_res;
  hbd_tx_t tx_ff, nxt_tx;
  logic frame_rst;
  logic [7:0] check_byte;
  logic [7:0] data_byte;

  // Selects the read data for an instruction code
  function automatic logic [7:0] hbd_read_data(input logic [OP_BITS-1:0] op,
                                               input logic [7:0] diag);
    case (op)
      OP_IDENT: hbd_read_data = DEVICE_ID;
      OP_VERSION: hbd_read_data = REVISION;
      OP_DIAG: hbd_read_data = diag;
      default: hbd_read_data = DATA_UNUSED;
    endcase
  endfunction : hbd_read_data

  // Slave select high holds the frame in its wait state
  assign frame_rst = i_link_rst | i_ss_n;
  assign check_byte = {2'b00, CHECK_PATTERN, i_prev_err};
  assign data_byte = hbd_read_data(fr_ff.op, i_diag);

  // Input side: sampled on the falling edge
  always_comb
  begin
    nxt_fr = fr_ff;
    // Extra clocks beyond the frame leave the word aligned for decoding
    if (fr_ff.cnt < CNT_FRAME)
    begin
      nxt_fr.shift = {fr_ff.shift[FRAME_BITS-2:0], i_sdi};
    end
    if (fr_ff.cnt != CNT_OVER)
    begin
      nxt_fr.cnt = fr_ff.cnt + CNT_ONE;
    end
    if (fr_ff.cnt == CNT_ADDR_LAST)
    begin
      nxt_fr.addr_ok = ({fr_ff.shift[0], i_sdi} == CHIP_ADDR);
    end
    // Data-phase bits shift in but never steer anything
    if (fr_ff.cnt == CNT_OP_LAST)
    begin
      nxt_fr.op = {fr_ff.shift[OP_BITS-2:0], i_sdi};
    end
  end

  always_ff @(negedge i_spi_clk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      fr_ff <= '0;
    end
    else
    begin
      fr_ff <= nxt_fr;
    end
  end

  // Result copy survives slave select; the toggle marks a clocked frame
  always_comb
  begin
    nxt_res.cnt = nxt_fr.cnt;
    nxt_res.word = nxt_fr.shift;
    nxt_res.tgl = (fr_ff.cnt == CNT_ZERO) ? ~res_ff.tgl : res_ff.tgl;
  end

  always_ff @(negedge i_spi_clk or posedge i_link_rst)
  begin
    if (i_link_rst)
    begin
      res_ff <= '0;
    end
    else
    begin
      res_ff <= nxt_res;
    end
  end

  // Output side: changes on the rising edge, silent until addressed
  always_comb
  begin
    nxt_tx.sdo = tx_ff.sdo;
    nxt_tx.oe_n = 1'b1;
    if (fr_ff.addr_ok && fr_ff.cnt >= CNT_CHK_FIRST &&
        fr_ff.cnt <= CNT_DATA_LAST)
    begin
      nxt_tx.oe_n = 1'b0;
      if (fr_ff.cnt <= CNT_OP_LAST)
      begin
        nxt_tx.sdo = check_byte[3'(CNT_OP_LAST - fr_ff.cnt)];
      end
      else
      begin
        nxt_tx.sdo = data_byte[3'(CNT_DATA_LAST - fr_ff.cnt)];
      end
    end
  end

  always_ff @(posedge i_spi_clk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      tx_ff <= '{sdo: 1'b0, oe_n: 1'b1};
    end
    else
    begin
      tx_ff <= nxt_tx;
    end
  end

  assign o_sdo = tx_ff.sdo;
  assign o_sdo_oe_n = tx_ff.oe_n;
  assign o_res_cnt = res_ff.cnt;
  assign o_res_word = res_ff.word;
  assign o_res_tgl = res_ff.tgl;

endmodule : hbd_spi_link

// >>> design/hbd_top.sv
// H-bridge drive control, fault latching, status flag and SPI diagnostics.
// Assumes analog comparators deliver fault levels as asynchronous pins.
module hbd_top
  import hbd_pkg::*;
#(
  parameter int LIMIT_OFF_CYCLES = LIMIT_OFF_CYCLES_DEF,
  parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] REVISION = 8'h00
)(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_shutoff_request,
  input wire logic i_run_permit,
  input wire logic i_drive_input_a,
  input wire logic i_drive_input_b,
  input wire logic i_short_out_a,
  input wire logic i_short_out_b,
  input wire logic i_short_between,
  input wire logic i_overcurrent,
  input wire logic i_overtemp,
  input wire logic i_undervoltage,
  input wire logic i_current_limit,
  input wire logic i_temp_current_reduce,
  input wire logic i_out_a_negative,
  input wire logic i_out_b_negative,
  input wire logic [3:0] i_output_diag,
  input wire logic i_diag_mode_select,
  input wire logic i_spi_clk,
  input wire logic i_ss_n,
  input wire logic i_sdi,
  output logic o_half_bridge_out_a_high,
  output logic o_half_bridge_out_a_low,
  output logic o_half_bridge_out_b_high,
  output logic o_half_bridge_out_b_low,
  output logic o_fault_flag_out,
  output logic o_fault_flag_oe_n,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  output logic o_latched_fault,
  output logic o_spi_mode
);

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic shutoff_q;
    logic permit_q;
    logic ss_q;
    logic dms_q;
    logic latched;
    logic [LIMIT_W-1:0] lim_cnt;
    hbd_exec_t st;
    logic [BUSY_W-1:0] busy_cnt;
    logic prev_err;
    logic over16;
    logic rst_pend;
    logic late;
    logic tgl_seen;
    logic [7:0] diag;
    logic [7:0] diag_snap;
    logic hs_a;
    logic ls_a;
    logic hs_b;
    logic ls_b;
    logic flag_oe_n;
  } hbd_state_t;

  hbd_state_t st_ff, nxt_st;
  logic [PIN_W-1:0] pins;
  logic link_rst;
  logic [CNT_W-1:0] res_cnt;
  logic [FRAME_BITS-1:0] res_word;
  logic res_tgl;

  // Synchronised pin levels, read only from the second stage
  logic shutoff, permit, in_a, in_b, neg_a, neg_b, ss_n, diag_mode_select;
  logic latch_cause, undervolt, rearm, tristate, flag_low;
  logic ss_rise, ss_fall, clocked, addressed, used, valid;
  logic [1:0] addr_bits;
  logic [7:0] live_diag;
  logic [OP_BITS-1:0] op;

  // True for the instruction codes that have a function
  function automatic logic hbd_op_used(input logic [OP_BITS-1:0] code);
    hbd_op_used = (code == OP_IDENT) || (code == OP_VERSION) ||
                  (code == OP_DIAG);
  endfunction : hbd_op_used

  // Pins gathered for the two-stage synchroniser
  assign pins[P_SHUTOFF] = i_shutoff_request;
  assign pins[P_PERMIT] = i_run_permit;
  assign pins[P_IN_A] = i_drive_input_a;
  assign pins[P_IN_B] = i_drive_input_b;
  assign pins[P_SHORT_A] = i_short_out_a;
  assign pins[P_SHORT_B] = i_short_out_b;
  assign pins[P_SHORT_AB] = i_short_between;
  assign pins[P_OVERCUR] = i_overcurrent;
  assign pins[P_OVERTEMP] = i_overtemp;
  assign pins[P_UNDERV] = i_undervoltage;
  assign pins[P_CURLIM] = i_current_limit;
  assign pins[P_CURRED] = i_temp_current_reduce;
  assign pins[P_NEG_A] = i_out_a_negative;
  assign pins[P_NEG_B] = i_out_b_negative;
  assign pins[P_ODIAG +: 4] = i_output_diag;
  assign pins[P_SS] = i_ss_n;
  assign pins[P_DMS] = i_diag_mode_select;

  assign shutoff = st_ff.s2[P_SHUTOFF];
  assign permit = st_ff.s2[P_PERMIT];
  assign in_a = st_ff.s2[P_IN_A];
  assign in_b = st_ff.s2[P_IN_B];
  assign neg_a = st_ff.s2[P_NEG_A];
  assign neg_b = st_ff.s2[P_NEG_B];
  assign ss_n = st_ff.s2[P_SS];
  assign diag_mode_select = st_ff.s2[P_DMS];

  // The link is held in reset straight from the pins; a glitch only
  // restarts the frame, which the master sees as an invalid access
  assign link_rst = i_rst | ~i_diag_mode_select;

  hbd_spi_link #(
    .DEVICE_ID(DEVICE_ID),
    .REVISION(REVISION)
  ) u_link (
    .i_spi_clk(i_spi_clk),
    .i_link_rst(link_rst),
    .i_ss_n(i_ss_n),
    .i_sdi(i_sdi),
    .i_prev_err(st_ff.prev_err),
    .i_diag(st_ff.diag_snap),
    .o_sdo(o_sdo),
    .o_sdo_oe_n(o_sdo_oe_n),
    .o_res_cnt(res_cnt),
    .o_res_word(res_word),
    .o_res_tgl(res_tgl)
  );

  // Fault classification
  assign latch_cause = st_ff.s2[P_SHORT_A] | st_ff.s2[P_SHORT_B] |
                       st_ff.s2[P_SHORT_AB] | st_ff.s2[P_OVERCUR] |
                       st_ff.s2[P_OVERTEMP];
  assign undervolt = st_ff.s2[P_UNDERV];
  assign rearm = (st_ff.shutoff_q & ~shutoff) |
                 (~st_ff.permit_q & permit);
  assign tristate = shutoff | ~permit | st_ff.latched | undervolt |
                    (st_ff.lim_cnt != '0);
  // Enable low leaves the flag released, as does a running current limit
  assign flag_low = st_ff.latched | undervolt | (shutoff & permit);

  // Live diagnostic bits; zero marks an error
  assign live_diag = {permit & ~shutoff,
                      ~st_ff.s2[P_OVERTEMP],
                      ~st_ff.s2[P_CURRED],
                      ~st_ff.s2[P_CURLIM],
                      st_ff.s2[P_ODIAG +: 4]};

  // Frame evaluation at the rising edge of select
  assign ss_rise = ~st_ff.ss_q & ss_n;
  assign ss_fall = st_ff.ss_q & ~ss_n;
  assign clocked = (res_tgl != st_ff.tgl_seen);
  // Short frames hold the address in the two bits shifted in first, at the top of the shifted bits
  assign addr_bits = (res_cnt >= CNT_FRAME) ? res_word[ADDR_HI:ADDR_LO] :
                     res_word[res_cnt - CNT_ONE -: $bits(CHIP_ADDR)];
  assign addressed = ~clocked || res_cnt < CNT_CHK_FIRST ||
                     addr_bits == CHIP_ADDR;
  assign op = res_word[OP_HI:OP_LO];
  assign used = hbd_op_used(op);
  assign valid = clocked && res_cnt == CNT_FRAME && used &&
                 ~st_ff.over16 && ~st_ff.late && ~st_ff.rst_pend;

  // Next-state logic for the whole block
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.shutoff_q = shutoff;
    nxt_st.permit_q = permit;
    nxt_st.ss_q = ss_n;
    nxt_st.dms_q = diag_mode_select;

    // Latched faults; a new cause wins over a re-arm in the same cycle
    if (rearm)
    begin
      nxt_st.latched = 1'b0;
    end
    if (latch_cause)
    begin
      nxt_st.latched = 1'b1;
    end

    // Current limit off-time, restarted while the limit persists
    if (st_ff.lim_cnt != '0)
    begin
      nxt_st.lim_cnt = st_ff.lim_cnt - LIMIT_W'(1);
    end
    else if (st_ff.s2[P_CURLIM])
    begin
      nxt_st.lim_cnt = LIMIT_W'(LIMIT_OFF_CYCLES);
    end

    // Bridge drive; when off, only the low side of a negative output
    nxt_st.hs_a = ~tristate & in_a;
    nxt_st.hs_b = ~tristate & in_b;
    nxt_st.ls_a = tristate ? neg_a : ~in_a;
    nxt_st.ls_b = tristate ? neg_b : ~in_b;

    // The flag pin is the serial clock in SPI mode, so never driven then
    nxt_st.flag_oe_n = diag_mode_select | ~flag_low;

    // Diagnostic register gathers errors as they come
    nxt_st.diag = st_ff.diag & live_diag;

    // Minimum access time after each executed frame
    if (st_ff.busy_cnt != '0)
    begin
      nxt_st.busy_cnt = st_ff.busy_cnt - BUSY_W'(1);
    end

    if (~diag_mode_select)
    begin
      // SPI held in default; the next instruction is marked invalid
      nxt_st.st = EX_IDLE;
      nxt_st.rst_pend = 1'b1;
      nxt_st.prev_err = 1'b0;
      nxt_st.over16 = 1'b0;
      nxt_st.late = 1'b0;
      nxt_st.busy_cnt = '0;
      nxt_st.tgl_seen = 1'b0;
      nxt_st.diag = DIAG_RESET;
    end
    else if (~st_ff.dms_q)
    begin
      nxt_st.diag = DIAG_RESET; // Entering SPI mode
    end
    else
    begin
      case (st_ff.st)
        EX_IDLE:
        begin
          if (ss_fall)
          begin
            // Freeze read data for the frame so the link sees a stable word
            nxt_st.diag_snap = {live_diag[DIAG_ACTIVE],
                                st_ff.diag[DIAG_ACTIVE-1:0]};
            nxt_st.late = (st_ff.busy_cnt != '0);
            nxt_st.st = EX_FRAME;
          end
        end
        EX_FRAME:
        begin
          if (ss_rise)
          begin
            nxt_st.st = EX_IDLE;
            nxt_st.tgl_seen = res_tgl;
            if (addressed)
            begin
              nxt_st.busy_cnt = BUSY_W'(ACCESS_CYCLES);
              nxt_st.prev_err = ~valid;
              nxt_st.over16 = clocked && res_cnt == CNT_OVER;
              nxt_st.late = 1'b0;
              nxt_st.rst_pend = 1'b0;
              // Only a valid diagnostic read reloads the register with the live bits
              if (valid && op == OP_DIAG)
              begin
                nxt_st.diag = live_diag;
              end
            end
          end
        end
        default:
        begin
          nxt_st.st = EX_IDLE;
        end
      endcase
    end
  end

  // Single register bank for all state
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_ff <= '{s1: '0, s2: '0, shutoff_q: 1'b0, permit_q: 1'b0,
                 ss_q: 1'b1, dms_q: 1'b0, latched: 1'b0, lim_cnt: '0,
                 st: EX_IDLE, busy_cnt: '0, prev_err: 1'b0,
                 over16: 1'b0, rst_pend: 1'b1, late: 1'b0,
                 tgl_seen: 1'b0, diag: DIAG_RESET,
                 diag_snap: DIAG_RESET, hs_a: 1'b0, ls_a: 1'b0,
                 hs_b: 1'b0, ls_b: 1'b0, flag_oe_n: 1'b1};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Open-drain flag: only ever pulls low
  assign o_fault_flag_out = 1'b0;
  assign o_fault_flag_oe_n = st_ff.flag_oe_n;
  assign o_half_bridge_out_a_high = st_ff.hs_a;
  assign o_half_bridge_out_a_low = st_ff.ls_a;
  assign o_half_bridge_out_b_high = st_ff.hs_b;
  assign o_half_bridge_out_b_low = st_ff.ls_b;
  assign o_latched_fault = st_ff.latched;
  assign o_spi_mode = diag_mode_select;

endmodule : hbd_top

// >>> sim/hbd_asserts.sv
// Concurrent checks on the H-bridge block ports, bound into hbd_top.
// Assumes the serial clock idles low and stands still outside frames.
module hbd_asserts
  import hbd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_shutoff_request,
  input wire logic i_run_permit,
  input wire logic i_undervoltage,
  input wire logic i_current_limit,
  input wire logic i_diag_mode_select,
  input wire logic i_spi_clk,
  input wire logic i_ss_n,
  input wire logic i_sdi,
  input wire logic o_half_bridge_out_a_high,
  input wire logic o_half_bridge_out_a_low,
  input wire logic o_half_bridge_out_b_high,
  input wire logic o_half_bridge_out_b_low,
  input wire logic o_fault_flag_oe_n,
  input wire logic o_sdo,
  input wire logic o_sdo_oe_n,
  input wire logic o_latched_fault,
  input wire logic o_spi_mode
);
  logic [5:0] shut_h;
  logic [5:0] perm_h;
  logic rearm;
  logic [CNT_W-1:0] fcnt;
  logic [1:0] addr_sh;
  logic hi_on;

  // Pin history, so a fault release can be traced to a re-arm edge
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      shut_h <= 6'h00;
      perm_h <= 6'h00;
    end
    else
    begin
      shut_h <= {shut_h[4:0], i_shutoff_request};
      perm_h <= {perm_h[4:0], i_run_permit};
    end
  end
  assign rearm = (|(shut_h[5:1] & ~shut_h[4:0])) ||
                 (|(~perm_h[5:1] & perm_h[4:0]));
  assign hi_on = o_half_bridge_out_a_high || o_half_bridge_out_b_high;

  // Falling edges of the frame and the two address bits
  always_ff @(negedge i_spi_clk or posedge i_ss_n)
  begin
    if (i_ss_n)
    begin
      fcnt <= CNT_ZERO;
      addr_sh <= 2'h0;
    end
    else
    begin
      fcnt <= fcnt + CNT_ONE;
      addr_sh <= (fcnt < CNT_CHK_FIRST) ? {addr_sh[0], i_sdi} : addr_sh;
    end
  end

  a_sel_off: assert property (@(posedge i_clock) disable iff (i_rst)
    i_ss_n |-> o_sdo_oe_n) else $error("sdo driven while deselected");
  a_latch_off: assert property (@(posedge i_clock) disable iff (i_rst)
    o_latched_fault |=> !hi_on) else $error("drive on while latched");
  a_no_shoot: assert property (@(posedge i_clock) disable iff (i_rst)
    !(o_half_bridge_out_a_high && o_half_bridge_out_a_low) &&
    !(o_half_bridge_out_b_high && o_half_bridge_out_b_low))
    else $error("both transistors of a half bridge on");
  a_rearm_only: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(o_latched_fault) |-> rearm) else $error("latch lost unarmed");
  a_limit_off: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(i_current_limit) |-> ##[3:5] !hi_on)
    else $error("current limit did not switch off");
  a_flag_spi: assert property (@(posedge i_clock) disable iff (i_rst)
    o_spi_mode && $past(o_spi_mode) |-> o_fault_flag_oe_n)
    else $error("flag pulled in serial mode");
  a_mode_sync: assert property (@(posedge i_clock) disable iff (i_rst)
    !$past(i_rst) && !$past(i_rst, 2) |->
    o_spi_mode == $past(i_diag_mode_select, 2))
    else $error("mode select not followed");
  a_underv_off: assert property (@(posedge i_clock) disable iff (i_rst)
    i_undervoltage [*5] |-> !hi_on && (o_spi_mode || !o_fault_flag_oe_n))
    else $error("undervoltage left drive on");
  a_addr_off: assert property (@(negedge i_spi_clk)
    disable iff (i_ss_n || !i_diag_mode_select)
    fcnt < CNT_CHK_FIRST || fcnt > CNT_DATA_LAST || addr_sh != CHIP_ADDR
    |-> o_sdo_oe_n) else $error("sdo driven outside answer");
  a_check_bits: assert property (@(negedge i_spi_clk)
    disable iff (i_ss_n || !i_diag_mode_select)
    fcnt >= CNT_CHK_FIRST && fcnt < CNT_OP_LAST && addr_sh == CHIP_ADDR
    |-> !o_sdo_oe_n && o_sdo == CHECK_PATTERN[5'h06 - fcnt])
    else $error("check byte pattern wrong");

  c_latch: cover property (@(posedge i_clock) $rose(o_latched_fault));
  c_limit: cover property (@(posedge i_clock) $rose(i_current_limit));
  c_frame: cover property (@(negedge i_spi_clk) fcnt == CNT_DATA_LAST);
endmodule : hbd_asserts

bind hbd_top hbd_asserts u_chk (.i_clock(i_clock), .i_rst(i_rst),
  .i_shutoff_request(i_shutoff_request), .i_run_permit(i_run_permit),
  .i_undervoltage(i_undervoltage), .i_current_limit(i_current_limit),
  .i_diag_mode_select(i_diag_mode_select), .i_spi_clk(i_spi_clk),
  .i_ss_n(i_ss_n), .i_sdi(i_sdi),
  .o_half_bridge_out_a_high(o_half_bridge_out_a_high),
  .o_half_bridge_out_a_low(o_half_bridge_out_a_low),
  .o_half_bridge_out_b_high(o_half_bridge_out_b_high),
  .o_half_bridge_out_b_low(o_half_bridge_out_b_low),
  .o_fault_flag_oe_n(o_fault_flag_oe_n), .o_sdo(o_sdo),
  .o_sdo_oe_n(o_sdo_oe_n), .o_latched_fault(o_latched_fault),
  .o_spi_mode(o_spi_mode));

// >>> sim/hbd_spi_master.sv
// Host side serial master model for the diagnostic link.
// Assumes the device drives its serial output only while enabled.
module hbd_spi_master
(
  input wire logic i_sdo,
  input wire logic i_sdo_oe_n,
  output logic o_spi_clk,
  output logic o_ss_n,
  output logic o_sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_bit = 1'b0;

  // Idle: clock low and still, select high, input pulled up
  initial
  begin
    o_spi_clk = 1'b0;
    o_ss_n = 1'b1;
    o_sdi = 1'b1;
  end

  // Released output reads as the inverse of its last driven level
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic [15:0] rx, output logic [15:0] drv);
    rx = 16'h0000;
    drv = 16'h0000;
    #3.3 o_ss_n = 1'b0;
    #200;
    for (int k = 0; k < n; k++)
    begin
      #250 o_spi_clk = 1'b1;
      o_sdi = (k < 16) ? tx[15 - k] : 1'b1;
      #250 o_spi_clk = 1'b0;
      if (k < 16)
      begin
        rx[15 - k] = i_sdo_oe_n ? ~last_bit : i_sdo;
        drv[15 - k] = ~i_sdo_oe_n;
      end
      last_bit = i_sdo_oe_n ? last_bit : i_sdo;
    end
    #200 o_ss_n = 1'b1;
    o_sdi = 1'b1;
  endtask : frame
endmodule : hbd_spi_master

// >>> sim/tb_top.sv
// Bench for the H-bridge block: bridge pins, faults and serial frames.
// Assumes the host master model and the bound checker are compiled.
module tb_top
  import hbd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 8;
  localparam logic [7:0] ID = 8'h5a; // Arbitrary value
  localparam logic [7:0] REV = 8'h00;
  logic clk = 1'b0, rst = 1'b1, shut = 1'b0, perm = 1'b1;
  logic in_a = 1'b0, in_b = 1'b0, uv = 1'b0, lim = 1'b0;
  logic neg_a = 1'b0, neg_b = 1'b0, diag_mode_select = 1'b0;
  logic [4:0] flt = 5'h00; // Short A, short B, between, overcurrent, temp
  wire logic spi_clk, ss_n, sdi;
  logic ah, al, bh, bl, flag, flag_oe_n, sdo, sdo_oe_n, latched, spi_mode;
  logic [15:0] rx, drv;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  hbd_top #(.LIMIT_OFF_CYCLES(LIMIT), .DEVICE_ID(ID), .REVISION(REV)) uut (
    .i_clock(clk), .i_rst(rst), .i_shutoff_request(shut),
    .i_run_permit(perm), .i_drive_input_a(in_a), .i_drive_input_b(in_b),
    .i_short_out_a(flt[0]), .i_short_out_b(flt[1]),
    .i_short_between(flt[2]), .i_overcurrent(flt[3]),
    .i_overtemp(flt[4]), .i_undervoltage(uv), .i_current_limit(lim),
    .i_temp_current_reduce(1'b0), .i_out_a_negative(neg_a),
    .i_out_b_negative(neg_b), .i_output_diag(4'hf),
    .i_diag_mode_select(diag_mode_select), .i_spi_clk(spi_clk), .i_ss_n(ss_n),
    .i_sdi(sdi), .o_half_bridge_out_a_high(ah),
    .o_half_bridge_out_a_low(al), .o_half_bridge_out_b_high(bh),
    .o_half_bridge_out_b_low(bl), .o_fault_flag_out(flag),
    .o_fault_flag_oe_n(flag_oe_n), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n),
    .o_latched_fault(latched), .o_spi_mode(spi_mode));
  hbd_spi_master host (.i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n),
    .o_spi_clk(spi_clk), .o_ss_n(ss_n), .o_sdi(sdi));

  always #4 clk = ~clk;

  // Ceiling well above the frame traffic, which needs about 25000 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fail_count = fail_count + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Order: high A, low A, high B, low B, flag released
  task automatic chk_br(input logic [4:0] exp);
    chk("bridge", {3'h0, exp}, {3'h0, ah, al, bh, bl, flag_oe_n});
    chk("flag", 8'h00, {7'h00, flag});
  endtask : chk_br

  // Data byte on the input is junk; a read must ignore it
  task automatic spi(input logic [7:0] cmd, input int n, input logic err,
                     input logic [7:0] data, input int gap);
    host.frame({cmd, 8'ha5}, n, rx, drv);
    chk("check", {2'h0, CHECK_PATTERN, err}, {2'h0, rx[13:8]});
    chk("data", data, rx[7:0]);
    cyc(gap);
  endtask : spi

  initial
  begin
    cyc(20);
    rst = 1'b0;
    cyc(6);
    for (int i = 0; i < 4; i++)
    begin
      in_a = i[1];
      in_b = i[0];
      cyc(6);
      chk_br({in_a, ~in_a, in_b, ~in_b, 1'b1});
    end
    shut = 1'b1;
    cyc(6);
    chk_br(5'h00);
    perm = 1'b0;
    cyc(6);
    chk_br(5'h01);
    {shut, perm, in_a, in_b} = 4'h6;
    cyc(6);
    chk_br(5'h13);
    // Each latching cause, released, then re-armed both ways
    for (int k = 0; k < 5; k++)
    begin
      flt[k] = 1'b1;
      cyc(3);
      flt[k] = 1'b0;
      cyc(6);
      chk_br(5'h00);
      chk("latched", 8'h01, {7'h00, latched});
      {neg_a, neg_b} = k[0] ? 2'h1 : 2'h2;
      cyc(6);
      chk_br(k[0] ? 5'h02 : 5'h08);
      {neg_a, neg_b} = 2'h0;
      perm = k[0] ? 1'b0 : 1'b1;
      shut = k[0] ? 1'b0 : 1'b1;
      cyc(4);
      {shut, perm} = 2'h1;
      cyc(6);
      chk_br(5'h13);
    end
    uv = 1'b1;
    cyc(6);
    chk_br(5'h00);
    uv = 1'b0;
    cyc(6);
    chk_br(5'h13);
    diag_mode_select = 1'b1;
    cyc(10);
    chk("mode", 8'h01, {7'h00, spi_mode});
    lim = 1'b1;
    cyc(3);
    lim = 1'b0;
    cyc(4);
    chk_br(5'h01);
    cyc(LIMIT + 8);
    chk_br(5'h13);
    spi({2'h0, OP_IDENT}, 16, 1'b0, ID, 1100);
    spi({2'h0, OP_IDENT}, 16, 1'b1, ID, 1100);
    spi({2'h0, OP_VERSION}, 16, 1'b0, REV, 1100);
    spi(8'h3f, 16, 1'b0, DATA_UNUSED, 1100);
    spi({2'h0, OP_DIAG}, 17, 1'b1, 8'hef, 1100);
    spi({2'h0, OP_DIAG}, 16, 1'b1, 8'hef, 1100);
    spi({2'h0, OP_DIAG}, 16, 1'b1, 8'hef, 1100);
    spi({2'h0, OP_DIAG}, 16, 1'b0, 8'hff, 1100);
    host.frame({8'h49, 8'h00}, 16, rx, drv);
    chk("drive", 8'h00, drv[15:8] | drv[7:0]);
    cyc(1100);
    spi({2'h0, OP_IDENT}, 16, 1'b0, ID, 10);
    spi({2'h0, OP_VERSION}, 16, 1'b0, REV, 1100);
    shut = 1'b1;
    cyc(6);
    spi({2'h0, OP_DIAG}, 16, 1'b1, 8'h7f, 1100);
    tally_and_finish();
  end
endmodule : tb_top
